// File: verilog/mpr_phase_ctrl.v
// Purpose: Per-motor phasing search, absolute phase referencing, phase reload,
//    velocity phase advance and back-path current gain.
// Assumes: All inputs synchronous to i_core_clk; i_servo_tick pulses once per servo cycle.
// Notes: Power-up sequence runs on the first cycle after reset release.
`timescale 1ns/10ps
`include "mpr_phase_map.vh"

module mpr_phase_ctrl (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst,
   // Motor configuration.
   input wire i_commutation_select,
   input wire [23:0] i_slip_gain_setting,
   input wire [23:0] i_absolute_phase_source,
   input wire [2:0] i_power_up_mode_selection,
   input wire [7:0] i_phase_find_time,
   input wire [23:0] i_phase_reference_offset,
   input wire [7:0] i_cycle_divisor,
   input wire [23:0] i_advance_or_back_path_gain,
   input wire [7:0] i_current_loop_adc_pointer,
   input wire [23:0] i_current_integral_gain,
   input wire [23:0] i_forward_proportional_gain,
   input wire i_second_variant,
   // Events.
   input wire i_servo_tick,
   input wire i_motor_reset_cmd,
   input wire i_phase_reload_command,
   // Feedback and command.
   input wire [23:0] i_absolute_sensor_pos,
   input wire [23:0] i_measured_velocity,
   input wire [15:0] i_phase_current,
   input wire [15:0] i_loop_command,
   // Phase state.
   output reg [23:0] o_phase_position,
   output reg [23:0] o_phase_angle,
   // Search drive.
   output reg o_search_active,
   output reg o_search_stepper,
   output reg o_drive_on,
   output reg [23:0] o_drive_angle,
   // Motor and current loop status.
   output reg o_motor_enabled,
   output reg [15:0] o_output_command,
   output reg o_back_path_active,
   output reg o_gain_config_error,
   output reg o_integral_only
);

   localparam ST_IDLE = 3'h0;
   localparam ST_GUESS0 = 3'h1;
   localparam ST_GUESS1 = 3'h2;
   localparam ST_STEP_A = 3'h3;
   localparam ST_STEP_B = 3'h4;

   reg [2:0] state;
   reg [2:0] next_state;
   reg power_up_pending;
   reg vel_sign0;
   reg timer_load;
   reg [`MPR_TIMER_WIDTH-1:0] timer_length;
   reg start_search;
   reg start_reference;
   reg next_enable;
   reg next_enable_load;
   wire timer_done;
   wire search_needed;
   wire abs_reference_ok;
   wire [`MPR_TIMER_WIDTH-1:0] guess_length;
   wire [`MPR_TIMER_WIDTH-1:0] step_length;
   wire [31:0] sensor_scaled;
   wire [23:0] reference_value;
   wire [47:0] advance_product;
   wire [23:0] advance_amount;
   wire [40:0] back_product;
   wire [17:0] back_term;
   wire [17:0] back_sum;
   wire back_enable;

   // Search qualifies only for a commutated synchronous motor without an absolute source.
   assign search_needed = i_commutation_select && (i_slip_gain_setting == 24'h000000) &&
      (i_absolute_phase_source == 24'h000000) && (i_phase_find_time != 8'h00);
   assign abs_reference_ok = i_commutation_select && (i_absolute_phase_source != 24'h000000);

   // Step lengths in servo cycles; the stepper form is 256 times longer.
   assign guess_length = {8'h00, i_phase_find_time};
   assign step_length = {i_phase_find_time, 8'h00};

   // Sensor position times the cycle divisor plus the signed offset, wrapped to 24 bits.
   assign sensor_scaled = $signed(i_absolute_sensor_pos) * $signed({1'b0, i_cycle_divisor});
   assign reference_value = sensor_scaled[23:0] + i_phase_reference_offset;

   // Velocity advance; the gain is never negative so its top bit is forced clear.
   assign advance_product = $signed(i_measured_velocity) * $signed({1'b0, i_advance_or_back_path_gain[22:0]});
   assign advance_amount = advance_product[`MPR_ADVANCE_SHIFT+23:`MPR_ADVANCE_SHIFT];

   // Back path: the gain is a fraction of one, so the shift folds in the factor of four.
   assign back_product = $signed(i_phase_current) * $signed({1'b0, i_advance_or_back_path_gain});
   assign back_term = back_product[`MPR_BACK_PATH_SHIFT+17:`MPR_BACK_PATH_SHIFT];
   assign back_sum = {{2{i_loop_command[15]}}, i_loop_command} - back_term;
   assign back_enable = i_second_variant && (i_current_loop_adc_pointer != 8'h00);

   mpr_tick_timer u_timer (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_load(timer_load),
      .i_length(timer_length),
      .i_tick(i_servo_tick),
      .o_done(timer_done)
   );

   // Decide what the power-up pass or a reset command starts, and the enable it leaves.
   always @* begin
      start_search = 1'b0;
      start_reference = 1'b0;
      next_enable = o_motor_enabled;
      next_enable_load = 1'b0;
      if (power_up_pending) begin
         next_enable = i_power_up_mode_selection[`MPR_MODE_ENABLE_BIT];
         next_enable_load = 1'b1;
         start_reference = abs_reference_ok && (i_power_up_mode_selection == `MPR_MODE_ABS_AUTO);
         start_search = search_needed && i_power_up_mode_selection[`MPR_MODE_ENABLE_BIT];
      end else if (i_motor_reset_cmd && (state == ST_IDLE)) begin
         next_enable = 1'b1;
         next_enable_load = 1'b1;
         start_reference = abs_reference_ok;
         start_search = search_needed;
      end
   end

   // Search sequencer: two guesses a quarter cycle apart, or two forced phases.
   always @* begin
      next_state = state;
      timer_load = 1'b0;
      timer_length = guess_length;
      case (state)
         ST_IDLE: begin
            if (start_search) begin
               timer_load = 1'b1;
               if (i_power_up_mode_selection[`MPR_MODE_METHOD_BIT]) begin
                  next_state = ST_STEP_A;
                  timer_length = step_length;
               end else begin
                  next_state = ST_GUESS0;
                  timer_length = guess_length;
               end
            end
         end
         ST_GUESS0: begin
            if (timer_done) begin
               next_state = ST_GUESS1;
               timer_load = 1'b1;
               timer_length = guess_length;
            end
         end
         ST_GUESS1: begin
            if (timer_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_STEP_A: begin
            if (timer_done) begin
               next_state = ST_STEP_B;
               timer_load = 1'b1;
               timer_length = step_length;
            end
         end
         ST_STEP_B: begin
            if (timer_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State, power-up flag and the guess response memory.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         state <= ST_IDLE;
         power_up_pending <= 1'b1;
         vel_sign0 <= 1'b0;
      end else begin
         state <= next_state;
         power_up_pending <= 1'b0;
         if ((state == ST_GUESS0) && timer_done) begin
            vel_sign0 <= i_measured_velocity[23];
         end
      end
   end

   // Phase position: reload wins, then referencing, then the end of a search.
   // The two-guess result picks the quadrant from the motion seen at each guess,
   // which is coarse by design; a later reload at a known position refines it.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_phase_position <= `MPR_PHASE_RESET;
      end else if (i_phase_reload_command) begin
         o_phase_position <= i_phase_reference_offset;
      end else if (start_reference) begin
         o_phase_position <= reference_value;
      end else if ((state == ST_GUESS1) && timer_done) begin
         case ({vel_sign0, i_measured_velocity[23]})
            2'b00: o_phase_position <= `MPR_ANGLE_ZERO;
            2'b01: o_phase_position <= `MPR_ANGLE_QUARTER;
            2'b11: o_phase_position <= `MPR_ANGLE_HALF;
            default: o_phase_position <= `MPR_ANGLE_THREE_Q;
         endcase
      end else if ((state == ST_STEP_B) && timer_done) begin
         // The motor now rests at the zero point of its commutation cycle.
         o_phase_position <= `MPR_ANGLE_ZERO;
      end
   end

   // Search drive outputs follow the state that is being entered.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_search_active <= 1'b0;
         o_search_stepper <= 1'b0;
         o_drive_on <= 1'b0;
         o_drive_angle <= `MPR_ANGLE_ZERO;
      end else begin
         o_search_active <= (next_state != ST_IDLE);
         o_drive_on <= (next_state != ST_IDLE);
         o_search_stepper <= (next_state == ST_STEP_A) || (next_state == ST_STEP_B);
         case (next_state)
            ST_GUESS1: o_drive_angle <= `MPR_ANGLE_QUARTER;
            ST_STEP_B: o_drive_angle <= `MPR_ANGLE_QUARTER;
            default: o_drive_angle <= `MPR_ANGLE_ZERO;
         endcase
      end
   end

   // Motor enable state from power-up mode or a reset command.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_motor_enabled <= 1'b0;
      end else if (next_enable_load) begin
         o_motor_enabled <= next_enable;
      end
   end

   // Commutation angle, advanced by velocity on the first variant only.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_phase_angle <= `MPR_PHASE_RESET;
      end else if (!i_second_variant) begin
         o_phase_angle <= o_phase_position + advance_amount;
      end else begin
         o_phase_angle <= o_phase_position;
      end
   end

   // Output command with the back-path term, saturated so a large current cannot wrap it.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_output_command <= `MPR_CMD_RESET;
         o_back_path_active <= 1'b0;
      end else if (back_enable) begin
         o_back_path_active <= 1'b1;
         if ((back_sum[17:15] == 3'h0) || (back_sum[17:15] == 3'h7)) begin
            o_output_command <= back_sum[15:0];
         end else if (back_sum[17]) begin
            o_output_command <= 16'h8000;
         end else begin
            o_output_command <= 16'h7FFF;
         end
      end else begin
         o_back_path_active <= 1'b0;
         o_output_command <= i_loop_command;
      end
   end

   // Gain sanity flags for the digital current loop.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_gain_config_error <= 1'b0;
         o_integral_only <= 1'b0;
      end else begin
         o_gain_config_error <= back_enable && (i_advance_or_back_path_gain == 24'h000000) &&
            (i_forward_proportional_gain == 24'h000000);
         o_integral_only <= back_enable && (i_advance_or_back_path_gain != 24'h000000) &&
            (i_forward_proportional_gain == 24'h000000) &&
            (i_current_integral_gain != 24'h000000);
      end
   end

endmodule // mpr_phase_ctrl

// File: verilog/mpr_phase_map.vh
// Purpose: Shared constants for the motor phasing reference control block.
// Assumes: 24-bit phase position words, 16-bit command and current words.
// Notes: Definitions only; included by bare name.
`ifndef MPR_PHASE_MAP_VH
`define MPR_PHASE_MAP_VH

// Power-up mode selection field positions.
`define MPR_MODE_ENABLE_BIT 0
`define MPR_MODE_METHOD_BIT 1
// Mode value that requests absolute referencing at power-up.
`define MPR_MODE_ABS_AUTO 3'h1

// Stepper-style search scales the find time by 256 servo cycles.
`define MPR_STEP_SCALE_SHIFT 8
`define MPR_TIMER_WIDTH 16

// Drive angles and two-guess search results, fractions of one commutation cycle.
`define MPR_ANGLE_ZERO 24'h000000
`define MPR_ANGLE_QUARTER 24'h400000
`define MPR_ANGLE_HALF 24'h800000
`define MPR_ANGLE_THREE_Q 24'hC00000

// Fraction points of the two gains.
`define MPR_ADVANCE_SHIFT 23
`define MPR_BACK_PATH_SHIFT 22

// Reset values.
`define MPR_PHASE_RESET 24'h000000
`define MPR_CMD_RESET 16'h0000

`endif

// File: verilog/mpr_tick_timer.v
// Purpose: Servo-cycle down counter used to time each phasing search step.
// Assumes: i_tick is a one-cycle pulse per servo interrupt cycle.
// Notes: o_done pulses one cycle after the tick that ends the loaded length.
`timescale 1ns/10ps
`include "mpr_phase_map.vh"

module mpr_tick_timer (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst,
   // Control.
   input wire i_load,
   input wire [`MPR_TIMER_WIDTH-1:0] i_length,
   input wire i_tick,
   // Status.
   output reg o_done
);

   reg [`MPR_TIMER_WIDTH-1:0] count;

   // A load restarts the count; the last tick of a running count raises done.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         count <= 16'h0000;
         o_done <= 1'b0;
      end else if (i_load) begin
         count <= i_length;
         o_done <= 1'b0;
      end else begin
         o_done <= i_tick && (count == 16'h0001);
         if (i_tick && (count != 16'h0000)) begin
            count <= count - 16'h0001;
         end
      end
   end

endmodule // mpr_tick_timer

// File: testbench/mpr_phase_checker.sv
// Purpose: Port checker for the phasing reference control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound from the testbench top file.
`timescale 1ns/10ps
module mpr_phase_checker (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Watched inputs.
   input wire logic i_commutation_select,
   input wire logic [23:0] i_slip_gain_setting,
   input wire logic [23:0] i_absolute_phase_source,
   input wire logic [2:0] i_power_up_mode_selection,
   input wire logic [7:0] i_phase_find_time,
   input wire logic [23:0] i_phase_reference_offset,
   input wire logic [23:0] i_advance_or_back_path_gain,
   input wire logic [7:0] i_current_loop_adc_pointer,
   input wire logic [23:0] i_current_integral_gain,
   input wire logic [23:0] i_forward_proportional_gain,
   input wire logic i_second_variant,
   input wire logic i_phase_reload_command,
   input wire logic [15:0] i_loop_command,
   // Watched outputs.
   input wire logic [23:0] o_phase_position,
   input wire logic o_search_active,
   input wire logic o_search_stepper,
   input wire logic o_drive_on,
   input wire logic [23:0] o_drive_angle,
   input wire logic [15:0] o_output_command,
   input wire logic o_back_path_active,
   input wire logic o_gain_config_error,
   input wire logic o_integral_only
);
   // Back path is live only in the second variant with a current loop running.
   wire bp_en = i_second_variant && (i_current_loop_adc_pointer != 8'h00);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_drive_follows_search: assert property (o_drive_on == o_search_active &&
      (o_search_active || o_drive_angle == 24'h000000))
      else $error("drive enable or idle angle differs from search state");
   a_reload_copies: assert property (i_phase_reload_command |-> ##[1:2] o_phase_position == i_phase_reference_offset)
      else $error("reload did not copy the offset");
   a_search_qualified: assert property ($rose(o_search_active) |-> $past(i_commutation_select
      && i_slip_gain_setting == 24'h000000 && i_absolute_phase_source == 24'h000000 && i_phase_find_time != 8'h00))
      else $error("search started for an unqualified motor");
   a_method_bit: assert property ($rose(o_search_active) |-> o_search_stepper == $past(i_power_up_mode_selection[1]))
      else $error("search method does not match mode bit");
   a_first_angle: assert property ($rose(o_search_active) |-> o_drive_angle == 24'h000000)
      else $error("first drive angle not zero");
   a_back_gate: assert property (o_back_path_active |-> $past(bp_en))
      else $error("back path active without current loop");
   a_plain_command: assert property (!$past(i_rst) && !$past(bp_en) |-> o_output_command == $past(i_loop_command))
      else $error("command altered without back path");
   a_gain_error: assert property (!$past(i_rst) |-> o_gain_config_error == $past(bp_en
      && i_advance_or_back_path_gain == 24'h000000 && i_forward_proportional_gain == 24'h000000))
      else $error("gain error flag wrong");
   a_integral_only: assert property (!$past(i_rst) |-> o_integral_only == $past(bp_en && i_advance_or_back_path_gain
      != 24'h000000 && i_forward_proportional_gain == 24'h000000 && i_current_integral_gain != 24'h000000))
      else $error("integral only flag wrong");
   // A stepper search leaves the rotor at the zero point of its cycle unless a reload overrides it.
   a_stepper_zero: assert property ($fell(o_search_active) && $past(o_search_stepper)
      && !$past(i_phase_reload_command) |-> o_phase_position == 24'h000000)
      else $error("stepper search did not end at phase zero");
   // Within one search the drive angle only ever moves on to the quarter cycle.
   a_second_angle: assert property (o_search_active && $past(o_search_active) && $changed(o_drive_angle)
      |-> o_drive_angle == 24'h400000)
      else $error("second drive angle not a quarter cycle");
   // Main scenarios reached.
   c_search: cover property ($rose(o_search_active));
   c_stepper: cover property ($rose(o_search_stepper));
   c_back_path: cover property (o_back_path_active);
   c_second_angle: cover property (o_search_active && o_drive_angle == 24'h400000);
endmodule // mpr_phase_checker

// File: testbench/mpr_amp_model.sv
// Purpose: Behavioural amplifier and motor facing the phasing block.
// Assumes: Velocity answers the drive one cycle late, as a real rotor lags.
// Notes: i_quad sets the sign seen under each guess, bit 1 for angle zero.
`timescale 1ns/10ps
module mpr_amp_model (
   // Clock.
   input wire logic i_core_clk,
   // Drive from the block.
   input wire logic i_drive_on,
   input wire logic [23:0] i_drive_angle,
   // Bench settings.
   input wire logic [1:0] i_quad,
   input wire logic [23:0] i_idle_velocity,
   // Feedback.
   output logic [23:0] o_measured_velocity,
   output logic [15:0] o_phase_current
);
   // The rotor swings one way or the other under each guessed field angle.
   always @(posedge i_core_clk) begin
      if (i_drive_on)
         o_measured_velocity <= ((i_drive_angle == 24'h000000) ? i_quad[1] : i_quad[0]) ? 24'hFFFF00 : 24'h000100;
      else
         o_measured_velocity <= i_idle_velocity;
   end
   // A fixed current level is enough to exercise the back path.
   assign o_phase_current = 16'h0100;
endmodule // mpr_amp_model

// File: testbench/test_mpr_phase_ctrl.sv
// Purpose: Self-checking bench for the phasing reference control block.
// Assumes: Inputs change at the falling edge; a servo tick every fourth cycle.
// Notes: Stepper search runs with find time 1, so 256 ticks per step.
`timescale 1ns/10ps
module test_mpr_phase_ctrl;
   reg clk, rst, comm, variant, rcmd, reload;
   reg tick = 1'b0;
   reg [1:0] tdiv = 2'h0;
   reg [23:0] slip, abs_src, offset, gain, integ, fwd;
   reg [2:0] mode;
   reg [7:0] find, adc;
   reg [1:0] quad;
   wire [23:0] vel, pos, angle, dangle;
   wire [15:0] cur, outcmd;
   wire active, stepper, drv, enabled, bp, gerr, ionly;
   integer bad_count, check_count, ticks, n, q;
   reg [23:0] quad_pos [0:3];

   mpr_phase_ctrl dut (.i_core_clk(clk), .i_rst(rst), .i_commutation_select(comm), .i_slip_gain_setting(slip),
      .i_absolute_phase_source(abs_src), .i_power_up_mode_selection(mode), .i_phase_find_time(find),
      .i_phase_reference_offset(offset), .i_cycle_divisor(8'h02), .i_advance_or_back_path_gain(gain),
      .i_current_loop_adc_pointer(adc), .i_current_integral_gain(integ), .i_forward_proportional_gain(fwd),
      .i_second_variant(variant), .i_servo_tick(tick), .i_motor_reset_cmd(rcmd), .i_phase_reload_command(reload),
      .i_absolute_sensor_pos(24'h000010), .i_measured_velocity(vel), .i_phase_current(cur),
      .i_loop_command(16'h1000), .o_phase_position(pos), .o_phase_angle(angle), .o_search_active(active),
      .o_search_stepper(stepper), .o_drive_on(drv), .o_drive_angle(dangle), .o_motor_enabled(enabled),
      .o_output_command(outcmd), .o_back_path_active(bp), .o_gain_config_error(gerr), .o_integral_only(ionly));
   mpr_amp_model amp (.i_core_clk(clk), .i_drive_on(drv), .i_drive_angle(dangle), .i_quad(quad),
      .i_idle_velocity(24'h000100), .o_measured_velocity(vel), .o_phase_current(cur));

   // Clock, servo tick and a count of ticks seen while searching.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) begin
      tdiv <= tdiv + 2'h1;
      tick <= (tdiv == 2'h3);
   end
   always @(posedge clk) if (active && tick) ticks = ticks + 1;

   task check(input [23:0] seen, input [23:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task cycles(input integer k);
      repeat (k) @(negedge clk);
   endtask
   // Which 0 gives a motor reset command, 1 a phase reload.
   task pulse(input integer which);
      begin
         if (which == 0) rcmd = 1'b1; else reload = 1'b1;
         cycles(1);
         rcmd = 1'b0;
         reload = 1'b0;
         cycles(1);
      end
   endtask
   task do_reset;
      begin
         rst = 1'b1;
         ticks = 0;
         cycles(10);
         rst = 1'b0;
         cycles(3);
      end
   endtask
   // Bounded wait; the longest search here lasts about 2100 cycles.
   task wait_idle;
      begin
         n = 0;
         while (active !== 1'b0 && n < 4000) begin
            cycles(1);
            n = n + 1;
         end
         // A search that outlasts the limit is a failure, as a tight following limit would kill the motor.
         if (n >= 4000) bad_count = bad_count + 1;
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   // A hang anywhere ends the run as a failure.
   initial begin
      #100000;
      bad_count = bad_count + 1;
      stop_test;
   end

   // Main sequence.
   initial begin
      rst = 1'b1; comm = 1'b1; variant = 1'b0; rcmd = 1'b0; reload = 1'b0; quad = 2'h0;
      slip = 24'h000000; abs_src = 24'h000001; offset = 24'h000005; mode = 3'h1; find = 8'h03;
      gain = 24'h000000; integ = 24'h000000; fwd = 24'h000000; adc = 8'h00;
      bad_count = 0; check_count = 0; ticks = 0;
      quad_pos[0] = 24'h000000; quad_pos[1] = 24'h400000; quad_pos[2] = 24'hC00000; quad_pos[3] = 24'h800000;
      do_reset;
      check(pos, 24'h000025);
      check(enabled, 1'b1);
      check(active, 1'b0);
      offset = 24'hFFFFF0;
      pulse(1);
      check(pos, 24'hFFFFF0);
      pulse(0);
      check(pos, 24'h000010);
      // Two-guess search with every sign pattern; find time 3 is in the advised range.
      abs_src = 24'h000000; mode = 3'h0;
      for (q = 0; q < 4; q = q + 1) begin
         quad = q[1:0];
         ticks = 0;
         pulse(0);
         check(active, 1'b1);
         wait_idle;
         check(ticks, 24'h000006);
         check(pos, quad_pos[q]);
      end
      find = 8'h00;
      pulse(0);
      cycles(2);
      check(active, 1'b0);
      check(pos, quad_pos[3]);
      find = 8'h03; slip = 24'h000001;
      pulse(0);
      cycles(2);
      check(active, 1'b0);
      slip = 24'h000000; find = 8'h01; mode = 3'h2;
      do_reset;
      check(enabled, 1'b0);
      check(active, 1'b0);
      mode = 3'h3;
      do_reset;
      check(active, 1'b1);
      check(stepper, 1'b1);
      wait_idle;
      check(ticks, 24'h000200);
      check(pos, 24'h000000);
      // Current loop and phase advance, position now zero.
      gain = 24'h400000;
      cycles(3);
      check(angle, 24'h000080);
      variant = 1'b1; adc = 8'h01;
      cycles(3);
      check(outcmd, 16'h0F00);
      check(bp, 1'b1);
      adc = 8'h00;
      cycles(3);
      check(outcmd, 16'h1000);
      adc = 8'h01; gain = 24'h000000;
      cycles(3);
      check(gerr, 1'b1);
      gain = 24'h400000; integ = 24'h000010;
      cycles(3);
      check(ionly, 1'b1);
      stop_test;
   end
endmodule // test_mpr_phase_ctrl

bind mpr_phase_ctrl mpr_phase_checker chk (.i_core_clk, .i_rst, .i_commutation_select, .i_slip_gain_setting,
   .i_absolute_phase_source, .i_power_up_mode_selection, .i_phase_find_time, .i_phase_reference_offset,
   .i_advance_or_back_path_gain, .i_current_loop_adc_pointer, .i_current_integral_gain,
   .i_forward_proportional_gain, .i_second_variant, .i_phase_reload_command, .i_loop_command, .o_phase_position,
   .o_search_active, .o_search_stepper, .o_drive_on, .o_drive_angle, .o_output_command, .o_back_path_active,
   .o_gain_config_error, .o_integral_only);
